// ==== pkg/didb_pkg.sv ====
package didb_pkg;
    // clock and sampling
    localparam int          CLK_PERIOD_NS    = 100;
    localparam int          SAMPLE_PERIOD_NS = 800;
    localparam int          SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          TICK_W           = 3;
    localparam int          CNT_W            = 17;
    // register bus
    localparam int          ADDR_W           = 4;
    localparam int          DATA_W           = 16;
    localparam logic [3:0]  OFS_CFG_A        = 4'h0;
    localparam logic [3:0]  OFS_CFG_B        = 4'h1;
    localparam logic [3:0]  OFS_GPIO_CFG     = 4'h2;
    localparam logic [3:0]  OFS_COMP_OUT     = 4'h3;
    localparam logic [3:0]  OFS_EDGE_CNT     = 4'h4;
    localparam logic [3:0]  OFS_FUNC_SEL     = 4'h5;
    localparam logic [3:0]  OFS_DAC_CODE     = 4'h6;
    localparam logic [3:0]  OFS_CONV_RESULT  = 4'h7;
    // input_config_a fields
    localparam int          CFGA_TIME_LSB    = 0;
    localparam int          CFGA_MODE_BIT    = 5;
    localparam int          CFGA_INV_BIT     = 6;
    localparam int          CFGA_CNTEN_BIT   = 7;
    localparam logic [15:0] CFGA_RESET       = 16'h0000;
    // input_config_b fields
    localparam int          CFGB_UNBUF_BIT   = 0;
    localparam logic [15:0] CFGB_RESET       = 16'h0000;
    // gpio_pin_config: select code that drives the debounced input out
    localparam logic [2:0]  GPIO_SEL_DIN     = 3'h3;
    localparam logic [2:0]  GPIO_RESET       = 3'h0;
    // channel_function_select codes
    localparam logic [1:0]  FUNC_HIZ         = 2'h0;
    localparam logic [1:0]  FUNC_DIN         = 2'h1;
    localparam logic [1:0]  FUNC_DIN_LOOP    = 2'h2;
    localparam logic [1:0]  FUNC_RESET       = 2'h0;
    localparam int          DAC_W            = 14;
    localparam logic [13:0] DAC_RESET        = 14'h0000;
    // adc default in loop powered input: terminal voltage, 0 to 12 V unipolar
    localparam logic [1:0]  ADC_MUX_IDLE     = 2'h0;
    localparam logic [1:0]  ADC_MUX_TERMINAL = 2'h1;
    localparam logic [1:0]  ADC_RANGE_0_12V  = 2'h1;
    localparam int          ADC_FULL_SCALE   = 65536;
    localparam int          ADC_RANGE_MV     = 12000;

    // debounce times in units of 100 ns, codes 01 to 1f
    localparam int DEB_TIME_100NS [1:31] = '{
        130, 187, 244, 325, 423, 561, 756, 1008, 1301, 1805, 2406, 3203,
        4203, 5602, 7504, 10008, 13008, 18008, 24008, 32008, 42008, 56008,
        75007, 100007, 130007, 180006, 240006, 320005, 420004, 560003, 750000};
    localparam int DEB_UNIT_NS = 100;

    // sample count for a debounce code, least time rounded up
    function automatic logic [CNT_W-1:0] debTarget(input logic [4:0] code);
        int ns;
        ns = 0;
        if (code != 5'h00) begin
            ns = DEB_TIME_100NS[code] * DEB_UNIT_NS;
        end
        return CNT_W'((ns + SAMPLE_PERIOD_NS - 1) / SAMPLE_PERIOD_NS);
    endfunction
endpackage

// ==== design/didb_debounce.sv ====
`timescale 1ns/10ps
`default_nettype none
module didb_debounce
    import didb_pkg::*;
(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // samples
    input  wire logic             sampleTick,
    input  wire logic             sampleVal,
    // configuration
    input  wire logic             bypass,
    input  wire logic             modeSel,
    input  wire logic [CNT_W-1:0] target,
    // result
    output var  logic             debOut
);
    logic             debOut_ff;
    logic             nxt_debOut;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // counting core, acts only on a new sample
    always_comb begin
        nxt_debOut = debOut_ff;
        nxt_cnt    = cnt_ff;
        if (sampleTick) begin
            if (bypass) begin
                nxt_debOut = sampleVal;
                nxt_cnt    = '0;
            end else if (!modeSel) begin
                // integrating count: away from state counts up, back counts down
                if (sampleVal != debOut_ff) begin
                    if (cnt_ff + CNT_W'(1) >= target) begin
                        nxt_debOut = sampleVal;
                        nxt_cnt    = '0;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_W'(1);
                    end
                end else if (cnt_ff != '0) begin
                    nxt_cnt = cnt_ff - CNT_W'(1);
                end
            end else begin
                // mode 1: the new state must persist unbroken
                if (sampleVal != debOut_ff) begin
                    if (cnt_ff + CNT_W'(1) >= target) begin
                        nxt_debOut = ~debOut_ff;
                        nxt_cnt    = '0;
                    end else begin
                        nxt_cnt = cnt_ff + CNT_W'(1);
                    end
                end else begin
                    nxt_cnt = '0;
                end
            end
        end
    end

    // starts low with an empty counter
    always_ff @(posedge mclk) begin
        if (reset) begin
            debOut_ff <= 1'b0;
            cnt_ff    <= '0;
        end else begin
            debOut_ff <= nxt_debOut;
            cnt_ff    <= nxt_cnt;
        end
    end

    assign debOut = debOut_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence diffSample_s;
        sampleTick && !bypass && (sampleVal != debOut_ff);
    endsequence

    bypass_follow_a: assert property (sampleTick && bypass |=> debOut_ff == $past(sampleVal))
        else $error("bypass does not pass the sample");
    mode1_clear_a: assert property (sampleTick && !bypass && modeSel && sampleVal == debOut_ff |=> cnt_ff == '0)
        else $error("mode 1 counter not cleared");
    mode0_down_a: assert property (sampleTick && !bypass && !modeSel && sampleVal == debOut_ff && cnt_ff != '0
                                   |=> cnt_ff == $past(cnt_ff) - CNT_W'(1))
        else $error("mode 0 counter did not count back");
    count_up_a: assert property (diffSample_s ##0 (cnt_ff + CNT_W'(1) < target)
                                 |=> cnt_ff == $past(cnt_ff) + CNT_W'(1) && $stable(debOut_ff))
        else $error("counter did not count toward target");
    target_flip_a: assert property (diffSample_s ##0 (cnt_ff + CNT_W'(1) >= target)
                                    |=> debOut_ff != $past(debOut_ff) && cnt_ff == '0)
        else $error("output did not change at target");
    no_tick_a: assert property (!sampleTick |=> $stable(debOut_ff) && $stable(cnt_ff))
        else $error("debounce moved without a sample");
endmodule
`default_nettype wire

// ==== design/didb_top.sv ====
// Operation
// - comparator watches buffered sense pin; unbuffered enable selects output pin instead
// - comparator output is sampled periodically; only samples enter the debouncer
// - sample clock period is about 800 ns
// - five-bit debounce time code; code zero bypasses the debouncer
// - nonzero codes map to table durations from 0.0130 ms to 75 ms
// - one mode bit selects debounce mode 0 or 1; mode 0 after reset
// - mode 0: differing samples count one way, agreeing samples the other
// - mode 0: count starts on difference and reverses when input returns
// - mode 0: output takes comparator state when the count reaches target
// - mode 1: differing samples count up; at target output toggles, counter clears
// - mode 1: a sample equal to the output clears the counter
// - conditioned input reaches status register and/or first gpio pin
// - first gpio pin drives debounced signal when configured for it
// - loop powered mode sources high-side current limited by dac code
// - loop powered mode adc defaults to terminal voltage, 0 to 12 V
// - configuration bit optionally inverts the debounced signal before status
// - edge counter clears on reset, wraps at full scale, holds when disabled
//
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module didb_top
    import didb_pkg::*;
(
    // clock and reset
    input  wire logic              mclk,
    input  wire logic              reset,
    // register port
    input  wire logic [ADDR_W-1:0] regAddr,
    input  wire logic [DATA_W-1:0] regWdata,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output var  logic [DATA_W-1:0] regRdata,
    // comparator outputs, asynchronous
    input  wire logic              compSenseIn,
    input  wire logic              compOutPinIn,
    // adc result from the converter logic
    input  wire logic [DATA_W-1:0] adcResult,
    // analog front end controls
    output var  logic              compUnbufSel,
    output var  logic              loopSourceEn,
    output var  logic [DAC_W-1:0]  dacCode,
    output var  logic [1:0]        adcMuxSel,
    output var  logic [1:0]        adcRange,
    // first gpio pin
    output var  logic              gpioOut,
    output var  logic              gpioOe
);
    // configuration registers
    logic [4:0]        debTime_ff;
    logic              debMode_ff;
    logic              invert_ff;
    logic              cntEn_ff;
    logic              unbuf_ff;
    logic [2:0]        gpioSel_ff;
    logic [1:0]        funcSel_ff;
    logic [DAC_W-1:0]  dac_ff;
    logic [4:0]        nxt_debTime;
    logic              nxt_debMode;
    logic              nxt_invert;
    logic              nxt_cntEn;
    logic              nxt_unbuf;
    logic [2:0]        nxt_gpioSel;
    logic [1:0]        nxt_funcSel;
    logic [DAC_W-1:0]  nxt_dac;
    // synchronisers and sampling
    logic              senseMeta_ff;
    logic              senseSync_ff;
    logic              pinMeta_ff;
    logic              pinSync_ff;
    logic [TICK_W-1:0] tick_ff;
    logic [TICK_W-1:0] nxt_tick;
    logic              sampleTick_ff;
    logic              nxt_sampleTick;
    logic              sample_ff;
    logic              nxt_sample;
    // debounced result and its users
    logic              debOut;
    logic              status;
    logic              statusPrev_ff;
    logic [DATA_W-1:0] edgeCnt_ff;
    logic [DATA_W-1:0] nxt_edgeCnt;
    logic              gpioOut_ff;
    logic              gpioOe_ff;
    logic              nxt_gpioOut;
    logic              nxt_gpioOe;
    // bus read path and front end outputs
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic              loop_ff;
    logic [1:0]        adcMux_ff;
    logic [1:0]        adcRange_ff;
    logic              nxt_loop;
    logic [1:0]        nxt_adcMux;
    logic [1:0]        nxt_adcRange;

    // register writes; unmapped and read-only offsets ignore writes
    always_comb begin
        nxt_debTime = debTime_ff;
        nxt_debMode = debMode_ff;
        nxt_invert  = invert_ff;
        nxt_cntEn   = cntEn_ff;
        nxt_unbuf   = unbuf_ff;
        nxt_gpioSel = gpioSel_ff;
        nxt_funcSel = funcSel_ff;
        nxt_dac     = dac_ff;
        if (regWr) begin
            unique case (regAddr)
                OFS_CFG_A: begin
                    nxt_debTime = regWdata[CFGA_TIME_LSB +: 5];
                    nxt_debMode = regWdata[CFGA_MODE_BIT];
                    nxt_invert  = regWdata[CFGA_INV_BIT];
                    nxt_cntEn   = regWdata[CFGA_CNTEN_BIT];
                end
                OFS_CFG_B:    nxt_unbuf   = regWdata[CFGB_UNBUF_BIT];
                OFS_GPIO_CFG: nxt_gpioSel = regWdata[2:0];
                OFS_FUNC_SEL: nxt_funcSel = regWdata[1:0];
                OFS_DAC_CODE: nxt_dac     = regWdata[DAC_W-1:0];
                default: ;
            endcase
        end
    end

    // mode 0 is the reset default
    always_ff @(posedge mclk) begin
        if (reset) begin
            debTime_ff <= CFGA_RESET[CFGA_TIME_LSB +: 5];
            debMode_ff <= CFGA_RESET[CFGA_MODE_BIT];
            invert_ff  <= CFGA_RESET[CFGA_INV_BIT];
            cntEn_ff   <= CFGA_RESET[CFGA_CNTEN_BIT];
            unbuf_ff   <= CFGB_RESET[CFGB_UNBUF_BIT];
            gpioSel_ff <= GPIO_RESET;
            funcSel_ff <= FUNC_RESET;
            dac_ff     <= DAC_RESET;
        end else begin
            debTime_ff <= nxt_debTime;
            debMode_ff <= nxt_debMode;
            invert_ff  <= nxt_invert;
            cntEn_ff   <= nxt_cntEn;
            unbuf_ff   <= nxt_unbuf;
            gpioSel_ff <= nxt_gpioSel;
            funcSel_ff <= nxt_funcSel;
            dac_ff     <= nxt_dac;
        end
    end

    // both comparator paths are synchronised so a mode switch never sees metastability
    always_ff @(posedge mclk) begin
        if (reset) begin
            senseMeta_ff <= 1'b0;
            senseSync_ff <= 1'b0;
            pinMeta_ff   <= 1'b0;
            pinSync_ff   <= 1'b0;
        end else begin
            senseMeta_ff <= compSenseIn;
            senseSync_ff <= senseMeta_ff;
            pinMeta_ff   <= compOutPinIn;
            pinSync_ff   <= pinMeta_ff;
        end
    end

    // sample divider: one tick every 800 ns, then capture the selected comparator
    always_comb begin
        nxt_tick       = (tick_ff == TICK_W'(SAMPLE_CYCLES - 1)) ? '0 : tick_ff + TICK_W'(1);
        nxt_sampleTick = (tick_ff == TICK_W'(SAMPLE_CYCLES - 1));
        nxt_sample     = sample_ff;
        if (nxt_sampleTick) begin
            nxt_sample = unbuf_ff ? pinSync_ff : senseSync_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tick_ff       <= '0;
            sampleTick_ff <= 1'b0;
            sample_ff     <= 1'b0;
        end else begin
            tick_ff       <= nxt_tick;
            sampleTick_ff <= nxt_sampleTick;
            sample_ff     <= nxt_sample;
        end
    end

    // the debouncer sees the held sample on the cycle after its capture
    didb_debounce u_debounce (
        .mclk       (mclk),
        .reset      (reset),
        .sampleTick (sampleTick_ff),
        .sampleVal  (sample_ff),
        .bypass     (debTime_ff == 5'h00),
        .modeSel    (debMode_ff),
        .target     (debTarget(debTime_ff)),
        .debOut     (debOut)
    );

    // inversion sits before status, gpio and counter, so it picks the counted edge
    assign status = debOut ^ invert_ff;

    always_comb begin
        nxt_edgeCnt = edgeCnt_ff;
        if (cntEn_ff && status && !statusPrev_ff) begin
            nxt_edgeCnt = edgeCnt_ff + DATA_W'(1);
        end
        nxt_gpioOe  = (gpioSel_ff == GPIO_SEL_DIN);
        nxt_gpioOut = nxt_gpioOe & status;
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            statusPrev_ff <= 1'b0;
            edgeCnt_ff    <= '0;
            gpioOut_ff    <= 1'b0;
            gpioOe_ff     <= 1'b0;
        end else begin
            statusPrev_ff <= status;
            edgeCnt_ff    <= nxt_edgeCnt;
            gpioOut_ff    <= nxt_gpioOut;
            gpioOe_ff     <= nxt_gpioOe;
        end
    end

    // loop powered input: source current and default adc measurement
    always_comb begin
        nxt_loop     = (funcSel_ff == FUNC_DIN_LOOP);
        nxt_adcMux   = nxt_loop ? ADC_MUX_TERMINAL : ADC_MUX_IDLE;
        nxt_adcRange = nxt_loop ? ADC_RANGE_0_12V : 2'h0;
    end

    // read data valid only in the cycle after the strobe, zero otherwise
    always_comb begin
        nxt_rdata = '0;
        if (regRd) begin
            unique case (regAddr)
                OFS_CFG_A:       nxt_rdata = DATA_W'({cntEn_ff, invert_ff, debMode_ff, debTime_ff});
                OFS_CFG_B:       nxt_rdata = DATA_W'(unbuf_ff);
                OFS_GPIO_CFG:    nxt_rdata = DATA_W'(gpioSel_ff);
                OFS_COMP_OUT:    nxt_rdata = DATA_W'(status);
                OFS_EDGE_CNT:    nxt_rdata = edgeCnt_ff;
                OFS_FUNC_SEL:    nxt_rdata = DATA_W'(funcSel_ff);
                OFS_DAC_CODE:    nxt_rdata = DATA_W'(dac_ff);
                OFS_CONV_RESULT: nxt_rdata = adcResult;
                default:         nxt_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rdata_ff    <= '0;
            loop_ff     <= 1'b0;
            adcMux_ff   <= ADC_MUX_IDLE;
            adcRange_ff <= 2'h0;
        end else begin
            rdata_ff    <= nxt_rdata;
            loop_ff     <= nxt_loop;
            adcMux_ff   <= nxt_adcMux;
            adcRange_ff <= nxt_adcRange;
        end
    end

    assign regRdata     = rdata_ff;
    assign compUnbufSel = unbuf_ff;
    assign loopSourceEn = loop_ff;
    assign dacCode      = dac_ff;
    assign adcMuxSel    = adcMux_ff;
    assign adcRange     = adcRange_ff;
    assign gpioOut      = gpioOut_ff;
    assign gpioOe       = gpioOe_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    sequence tickPair_s;
        sampleTick_ff ##1 !sampleTick_ff [*7] ##1 sampleTick_ff;
    endsequence

    tick_period_a: assert property (sampleTick_ff |-> tickPair_s)
        else $error("sample tick period is not eight cycles");
    path_select_a: assert property (nxt_sampleTick |=> sample_ff == ($past(unbuf_ff) ? $past(pinSync_ff)
                                                                      : $past(senseSync_ff)))
        else $error("wrong comparator path sampled");
    count_hold_a: assert property (!cntEn_ff |=> $stable(edgeCnt_ff))
        else $error("edge counter moved while disabled");
    count_edge_a: assert property (cntEn_ff && status && !statusPrev_ff |=> edgeCnt_ff == $past(edgeCnt_ff) + 16'h0001)
        else $error("edge not counted");
    gpio_drive_a: assert property (gpioSel_ff == GPIO_SEL_DIN |=> gpioOe_ff && gpioOut_ff == $past(status))
        else $error("gpio does not carry the debounced input");
    status_read_a: assert property (regRd && regAddr == OFS_COMP_OUT |=> regRdata == DATA_W'($past(debOut ^ invert_ff)))
        else $error("status read does not show conditioned input");
    loop_adc_a: assert property (funcSel_ff == FUNC_DIN_LOOP |=> loopSourceEn && adcMuxSel == ADC_MUX_TERMINAL
                                 && adcRange == ADC_RANGE_0_12V)
        else $error("loop powered defaults not applied");
    mode_reset_a: assert property ($fell(reset) |-> !debMode_ff && !debOut)
        else $error("reset did not select mode 0 with low output");

    // the current limit and the pin release must follow their registers within one cycle
    dac_follow_a: assert property (regWr && regAddr == OFS_DAC_CODE |=> dacCode == $past(regWdata[DAC_W-1:0]))
        else $error("dac code not taken from the write");
    gpio_idle_a: assert property (gpioSel_ff != GPIO_SEL_DIN |=> !gpioOe_ff && !gpioOut_ff)
        else $error("gpio driven while not configured");
endmodule
`default_nettype wire

// ==== test/didb_sensor.sv ====
`timescale 1ns/10ps
`default_nettype none
// field sensor model: drives both comparator paths from levels set by the bench
module didb_sensor (
    // clock
    input  wire logic mclk,
    // levels commanded by the bench
    input  wire logic senseLvl,
    input  wire logic pinLvl,
    // comparator outputs seen by the block
    output var  logic compSenseIn,
    output var  logic compOutPinIn
);
    // changes land just after an edge, so the block's synchroniser sees a clean step
    always_ff @(posedge mclk) begin
        compSenseIn  <= senseLvl;
        compOutPinIn <= pinLvl;
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import didb_pkg::*;
    logic              mclk;
    logic              reset;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWdata;
    logic              regWr;
    logic              regRd;
    logic [DATA_W-1:0] regRdata;
    logic              senseLvl;
    logic              pinLvl;
    logic              compSenseIn;
    logic              compOutPinIn;
    logic [DATA_W-1:0] adcResult;
    logic              compUnbufSel;
    logic              loopSourceEn;
    logic [DAC_W-1:0]  dacCode;
    logic [1:0]        adcMuxSel;
    logic [1:0]        adcRange;
    logic              gpioOut;
    logic              gpioOe;
    int                n_fail;
    int                checks;

    didb_top u_dut (.mclk(mclk), .reset(reset), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .compSenseIn(compSenseIn),
        .compOutPinIn(compOutPinIn), .adcResult(adcResult), .compUnbufSel(compUnbufSel),
        .loopSourceEn(loopSourceEn), .dacCode(dacCode), .adcMuxSel(adcMuxSel),
        .adcRange(adcRange), .gpioOut(gpioOut), .gpioOe(gpioOe));

    didb_sensor u_sensor (.mclk(mclk), .senseLvl(senseLvl), .pinLvl(pinLvl),
        .compSenseIn(compSenseIn), .compOutPinIn(compOutPinIn));

    // 10 MHz clock
    always #50 mclk = ~mclk;

    task automatic summarize();
        if (n_fail == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge mclk);
        regWr    <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe, so look there
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd   <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask

    // registers, status and counter all zero after reset; unmapped reads zero
    task automatic t_reset();
        for (int i = 0; i < 9; i++) begin
            rd(4'(i), 16'h0000);
        end
        chk(16'({compUnbufSel, loopSourceEn, gpioOe, gpioOut}), 16'h0000);
    endtask

    // code zero passes samples straight through to status, gpio and counter
    task automatic t_bypass();
        wr(OFS_GPIO_CFG, 16'h0003);
        wr(OFS_CFG_A, 16'h0080);
        senseLvl <= 1'b1;
        waitc(24);
        rd(OFS_COMP_OUT, 16'h0001);
        chk(16'({gpioOe, gpioOut}), 16'h0003);
        rd(OFS_EDGE_CNT, 16'h0001);
        senseLvl <= 1'b0;
        waitc(24);
        rd(OFS_COMP_OUT, 16'h0000);
        chk(16'(gpioOut), 16'h0000);
        // count disabled: a further pulse must leave the counter frozen
        wr(OFS_CFG_A, 16'h0000);
        senseLvl <= 1'b1;
        waitc(24);
        senseLvl <= 1'b0;
        waitc(24);
        rd(OFS_EDGE_CNT, 16'h0001);
    endtask

    // unbuffered enable moves the comparator onto the output pin path
    task automatic t_unbuf();
        wr(OFS_CFG_B, 16'h0001);
        pinLvl <= 1'b1;
        waitc(24);
        chk(16'(compUnbufSel), 16'h0001);
        rd(OFS_COMP_OUT, 16'h0001);
        wr(OFS_CFG_B, 16'h0000);
        waitc(24);
        rd(OFS_COMP_OUT, 16'h0000);
        pinLvl <= 1'b0;
    endtask

    // code 1 needs 17 samples: 13 high, 2 low, 13 high settles mode 0 only
    task automatic t_debounce(input logic mode);
        wr(OFS_CFG_A, {10'h000, mode, 5'h01});
        senseLvl <= 1'b1;
        waitc(104);
        senseLvl <= 1'b0;
        waitc(16);
        senseLvl <= 1'b1;
        waitc(104);
        if (mode) begin
            rd(OFS_COMP_OUT, 16'h0000);
        end else begin
            rd(OFS_COMP_OUT, 16'h0001);
        end
        waitc(160);
        rd(OFS_COMP_OUT, 16'h0001);
        senseLvl <= 1'b0;
        waitc(200);
        rd(OFS_COMP_OUT, 16'h0000);
        wr(OFS_CFG_A, 16'h0000);
    endtask

    // inversion flips status and gpio, and its rising edge is counted
    task automatic t_invert();
        wr(OFS_CFG_A, 16'h00c0);
        waitc(24);
        rd(OFS_COMP_OUT, 16'h0001);
        chk(16'(gpioOut), 16'h0001);
        rd(OFS_EDGE_CNT, 16'h0002);
        wr(OFS_CFG_A, 16'h0000);
    endtask

    // loop powered function, read-only status refusing a write, back to high impedance
    task automatic t_loop();
        adcResult <= 16'h8000;
        wr(OFS_FUNC_SEL, 16'h0002);
        wr(OFS_DAC_CODE, 16'h1abc);
        waitc(2);
        chk(16'({loopSourceEn, dacCode}), 16'h5abc);
        chk(16'({adcMuxSel, adcRange}), 16'h0005);
        rd(OFS_CONV_RESULT, 16'h8000);
        wr(OFS_COMP_OUT, 16'hffff);
        rd(OFS_COMP_OUT, 16'h0000);
        wr(OFS_FUNC_SEL, 16'h0000);
        waitc(2);
        chk(16'({loopSourceEn, adcMuxSel, adcRange}), 16'h0000);
    endtask

    // reset in mid-run clears a nonzero edge counter and restores mode 0 and bypass
    task automatic t_reset2();
        wr(OFS_CFG_A, 16'h00a1);
        @(posedge mclk);
        reset <= 1'b1;
        waitc(2);
        reset <= 1'b0;
        rd(OFS_EDGE_CNT, 16'h0000);
        rd(OFS_CFG_A, 16'h0000);
        chk(16'({gpioOe, gpioOut}), 16'h0000);
    endtask

    initial begin
        mclk      = 1'b0;
        reset     = 1'b1;
        regAddr   = '0;
        regWdata  = '0;
        regWr     = 1'b0;
        regRd     = 1'b0;
        senseLvl  = 1'b0;
        pinLvl    = 1'b0;
        adcResult = '0;
        n_fail    = 0;
        checks    = 0;
        waitc(6);
        reset <= 1'b0;
        t_reset();
        t_bypass();
        t_unbuf();
        t_debounce(1'b0);
        t_debounce(1'b1);
        t_invert();
        t_loop();
        t_reset2();
        summarize();
    end

    // hang guard: counts as a mismatch and closes the run
    initial begin
        waitc(60000);
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
